// ### rtl/fps_program_store.sv
// Program flash access control: routing, key lock, read timing
`timescale 1ns/100ps
module fps_program_store #(
  parameter int ADDR_W = fps_pkg::ADDR_WIDTH,
  parameter int ROW_SIZE = fps_pkg::ROW_BYTES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic codeRd,
  input wire logic [ADDR_W-1:0] codeAddr,
  input wire logic dataWr,
  input wire logic [ADDR_W-1:0] dataAddr,
  input wire logic [7:0] dataWdata,
  output logic flashSenseEn,
  output logic flashLowPower,
  output logic codeScratch,
  output logic rowChange,
  output logic flashProgStb,
  output logic flashEraseStb,
  output logic flashOpScratch,
  output logic [ADDR_W-1:0] flashOpAddr,
  output logic [7:0] flashOpData,
  output logic ramWrStb,
  output logic [ADDR_W-1:0] ramWrAddr,
  output logic [7:0] ramWrData,
  output fps_pkg::fps_lock_t lockState
);
  import fps_pkg::*;

  localparam int ROW_SHIFT = $clog2(ROW_SIZE);

  if (ROW_SIZE < 2 || (1 << ROW_SHIFT) != ROW_SIZE || ADDR_W <= ROW_SHIFT) begin : gBadRow
    $error("ROW_SIZE must be a power of two below the address space");
  end

  // Row index of an address
  function automatic logic [ADDR_W-1:0] rowOf(input logic [ADDR_W-1:0] a);
    rowOf = a >> ROW_SHIFT;
  endfunction

  // Control bits
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;
  logic bypass_r;
  logic bypass_nxt;
  fps_lock_t lock_r;
  fps_lock_t lock_nxt;
  // Read data register
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // Row tracking
  logic [ADDR_W-1:0] lastRow_r;
  logic [ADDR_W-1:0] lastRow_nxt;
  logic rowChg_r;
  logic rowChg_nxt;
  logic codeScr_r;
  logic codeScr_nxt;
  // Flash operation outputs
  logic prog_r;
  logic prog_nxt;
  logic erase_r;
  logic erase_nxt;
  logic opScr_r;
  logic opScr_nxt;
  logic [ADDR_W-1:0] opAddr_r;
  logic [ADDR_W-1:0] opAddr_nxt;
  logic [7:0] opData_r;
  logic [7:0] opData_nxt;
  // External RAM write outputs
  logic ram_r;
  logic ram_nxt;
  logic [ADDR_W-1:0] ramAddr_r;
  logic [ADDR_W-1:0] ramAddr_nxt;
  logic [7:0] ramData_r;
  logic [7:0] ramData_nxt;

  // Decoded strobes
  logic wrEn;
  logic eraseEn;
  logic flashAttempt;
  logic keyWr;
  assign wrEn = ctrl_r[WR_EN_BIT];
  assign eraseEn = ctrl_r[ERASE_EN_BIT];
  assign flashAttempt = dataWr && wrEn;
  assign keyWr = sfrWr && (sfrAddr == KEY_LOCK_OFS);

  // Register writes and read mux
  always_comb begin
    ctrl_nxt = ctrl_r;
    bypass_nxt = bypass_r;
    rdata_nxt = rdata_r;
    if (sfrWr && sfrAddr == PROG_STORE_CTRL_OFS) begin
      ctrl_nxt = sfrWdata[2:0];
    end
    if (sfrWr && sfrAddr == READ_SCALE_OFS) begin
      bypass_nxt = sfrWdata[BYPASS_BIT];
    end
    if (sfrRd) begin
      unique case (sfrAddr)
        PROG_STORE_CTRL_OFS: rdata_nxt = {5'b0_0000, ctrl_r};
        KEY_LOCK_OFS: rdata_nxt = {6'b00_0000, lock_r};
        READ_SCALE_OFS: rdata_nxt = {1'b0, bypass_r, 6'b00_0000};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // Key lock sequence
  always_comb begin
    lock_nxt = lock_r;
    unique case (lock_r)
      LOCK_CLOSED: begin
        if (flashAttempt) begin
          lock_nxt = LOCK_DEAD;
        end else if (keyWr) begin
          lock_nxt = (sfrWdata == KEY_FIRST) ? LOCK_FIRST : LOCK_DEAD;
        end
      end
      LOCK_FIRST: begin
        if (flashAttempt) begin
          lock_nxt = LOCK_DEAD;
        end else if (keyWr) begin
          lock_nxt = (sfrWdata == KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
        end
      end
      LOCK_OPEN: begin
        if (flashAttempt) begin
          lock_nxt = LOCK_CLOSED;
        end else if (keyWr) begin
          lock_nxt = LOCK_DEAD;
        end
      end
      LOCK_DEAD: lock_nxt = LOCK_DEAD;
    endcase
  end

  // Write routing: flash program, page erase or external RAM
  always_comb begin
    prog_nxt = 1'b0;
    erase_nxt = 1'b0;
    ram_nxt = 1'b0;
    opScr_nxt = opScr_r;
    opAddr_nxt = opAddr_r;
    opData_nxt = opData_r;
    ramAddr_nxt = ramAddr_r;
    ramData_nxt = ramData_r;
    if (flashAttempt && lock_r == LOCK_OPEN) begin
      erase_nxt = eraseEn;
      prog_nxt = !eraseEn;
      opScr_nxt = ctrl_r[SCRATCH_BIT];
      opAddr_nxt = dataAddr;
      opData_nxt = eraseEn ? 8'hFF : dataWdata;
    end else if (dataWr && !wrEn) begin
      ram_nxt = 1'b1;
      ramAddr_nxt = dataAddr;
      ramData_nxt = dataWdata;
    end
  end

  // Code read routing and row tracking
  always_comb begin
    lastRow_nxt = lastRow_r;
    rowChg_nxt = 1'b0;
    codeScr_nxt = codeScr_r;
    if (codeRd) begin
      lastRow_nxt = rowOf(codeAddr);
      rowChg_nxt = rowOf(codeAddr) != lastRow_r;
      codeScr_nxt = ctrl_r[SCRATCH_BIT];
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
      bypass_r <= BYPASS_RESET;
      lock_r <= LOCK_CLOSED;
      rdata_r <= 8'h00;
      lastRow_r <= '0;
      rowChg_r <= 1'b0;
      codeScr_r <= 1'b0;
      prog_r <= 1'b0;
      erase_r <= 1'b0;
      opScr_r <= 1'b0;
      opAddr_r <= '0;
      opData_r <= 8'h00;
      ram_r <= 1'b0;
      ramAddr_r <= '0;
      ramData_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      bypass_r <= bypass_nxt;
      lock_r <= lock_nxt;
      rdata_r <= rdata_nxt;
      lastRow_r <= lastRow_nxt;
      rowChg_r <= rowChg_nxt;
      codeScr_r <= codeScr_nxt;
      prog_r <= prog_nxt;
      erase_r <= erase_nxt;
      opScr_r <= opScr_nxt;
      opAddr_r <= opAddr_nxt;
      opData_r <= opData_nxt;
      ram_r <= ram_nxt;
      ramAddr_r <= ramAddr_nxt;
      ramData_r <= ramData_nxt;
    end
  end

  // Sense-amplifier timing
  fps_sense_oneshot u_oneshot (
    .clk(clk),
    .sys_rst(sys_rst),
    .bypass(bypass_r),
    .access(codeRd),
    .senseEn(flashSenseEn)
  );

  assign flashLowPower = !flashSenseEn;
  assign sfrRdata = rdata_r;
  assign codeScratch = codeScr_r;
  assign rowChange = rowChg_r;
  assign flashProgStb = prog_r;
  assign flashEraseStb = erase_r;
  assign flashOpScratch = opScr_r;
  assign flashOpAddr = opAddr_r;
  assign flashOpData = opData_r;
  assign ramWrStb = ram_r;
  assign ramWrAddr = ramAddr_r;
  assign ramWrData = ramData_r;
  assign lockState = lock_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence keyPair;
    keyWr && sfrWdata == KEY_FIRST && lock_r == LOCK_CLOSED && !flashAttempt
      ##1 !keyWr && !flashAttempt
      ##1 keyWr && sfrWdata == KEY_SECOND && !flashAttempt;
  endsequence

  sense_pulse_a: assert property (codeRd && !bypass_r |=> flashSenseEn && flashLowPower == 0)
    else $error("no sense pulse after access");
  bypass_follow_a: assert property (bypass_r && !codeRd |=> !flashSenseEn)
    else $error("sense enable without access in bypass");
  bypass_clear_a: assert property (sfrWr && sfrAddr == READ_SCALE_OFS && !sfrWdata[BYPASS_BIT]
    |=> !bypass_r)
    else $error("bypass not cleared");
  row_change_a: assert property (codeRd |=> rowChange == (rowOf($past(codeAddr)) != $past(lastRow_r)))
    else $error("row change flag wrong");
  scratch_route_a: assert property (codeRd |=> codeScratch == $past(ctrl_r[SCRATCH_BIT]))
    else $error("code read routing wrong");
  page_erase_a: assert property (dataWr && wrEn && eraseEn && lock_r == LOCK_OPEN
    |=> flashEraseStb && !flashProgStb)
    else $error("page erase not issued");
  byte_prog_a: assert property (dataWr && wrEn && !eraseEn && lock_r == LOCK_OPEN
    |=> flashProgStb && flashOpData == $past(dataWdata))
    else $error("byte program not issued");
  unused_zero_a: assert property (sfrRd && sfrAddr == PROG_STORE_CTRL_OFS
    |=> sfrRdata[7:3] == 5'b0_0000)
    else $error("unused bits not zero");
  key_unlock_a: assert property (keyPair |=> lock_r == LOCK_OPEN)
    else $error("key pair did not unlock");
  relock_after_op_a: assert property (flashAttempt && lock_r == LOCK_OPEN |=> lock_r == LOCK_CLOSED)
    else $error("no relock after operation");
  locked_attempt_a: assert property (flashAttempt && lock_r != LOCK_OPEN
    |=> lock_r == LOCK_DEAD && !flashProgStb && !flashEraseStb)
    else $error("locked attempt not punished");
  dead_stays_a: assert property (lock_r == LOCK_DEAD |=> lock_r == LOCK_DEAD)
    else $error("permanent lock left");
  ram_route_a: assert property (dataWr && !wrEn && !keyWr
    |=> ramWrStb && !flashProgStb && !flashEraseStb && $stable(lock_r))
    else $error("write not routed to RAM");
endmodule

// ### rtl/fps_pkg.sv
// Shared constants for the program store access block
package fps_pkg;
  // Register offsets on the special-function register port
  localparam logic [7:0] PROG_STORE_CTRL_OFS = 8'h8F;
  localparam logic [7:0] KEY_LOCK_OFS = 8'hB6;
  localparam logic [7:0] READ_SCALE_OFS = 8'hB7;
  // Field positions
  localparam int WR_EN_BIT = 0;
  localparam int ERASE_EN_BIT = 1;
  localparam int SCRATCH_BIT = 2;
  localparam int BYPASS_BIT = 6;
  // Reset values
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic BYPASS_RESET = 1'b0;
  // Key codes
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  // Geometry
  localparam int ROW_BYTES = 128;
  localparam int ADDR_WIDTH = 16;
  localparam logic [15:0] SCRATCH_LAST = 16'h03FF;
  // Sense pulse timing
  localparam int SENSE_MIN_NS = 50;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SENSE_CYCLES = (SENSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Lock state, encoded as read back from the key register
  typedef enum logic [1:0] {
    LOCK_CLOSED = 2'b00,
    LOCK_FIRST = 2'b01,
    LOCK_OPEN = 2'b10,
    LOCK_DEAD = 2'b11
  } fps_lock_t;
endpackage

// ### rtl/fps_sense_oneshot.sv
// Sense-amplifier enable generator with one-shot and bypass modes
`timescale 1ns/100ps
module fps_sense_oneshot #(
  parameter int PULSE_CYCLES = fps_pkg::SENSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bypass,
  input wire logic access,
  output logic senseEn
);
  import fps_pkg::*;

  // Refuse pulse lengths the 8-bit counter cannot hold
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : gBadPulse
    $error("PULSE_CYCLES out of range");
  end

  // Remaining pulse length
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic sense_r;
  logic sense_nxt;

  // Fixed-width pulse per access, or follow the access when bypassed
  always_comb begin
    count_nxt = count_r;
    sense_nxt = 1'b0;
    if (bypass) begin
      count_nxt = 8'h00;
      sense_nxt = access;
    end else if (access) begin
      count_nxt = 8'(PULSE_CYCLES - 1);
      sense_nxt = 1'b1;
    end else if (count_r != 8'h00) begin
      count_nxt = count_r - 8'h01;
      sense_nxt = 1'b1;
    end
  end

  // Register the pulse state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= 8'h00;
      sense_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      sense_r <= sense_nxt;
    end
  end

  assign senseEn = sense_r;
endmodule

// ### verif/fps_core_model.sv
// Core-side model issuing register, code-read and data-move accesses
`timescale 1ns/100ps
module fps_core_model (
  input wire logic clk,
  output logic [7:0] sfrAddr,
  output logic sfrWr,
  output logic sfrRd,
  output logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  output logic codeRd,
  output logic [fps_pkg::ADDR_WIDTH-1:0] codeAddr,
  output logic dataWr,
  output logic [fps_pkg::ADDR_WIDTH-1:0] dataAddr,
  output logic [7:0] dataWdata
);
  import fps_pkg::*;
  // Idle bus at time zero
  initial begin
    {sfrAddr, sfrWr, sfrRd, sfrWdata} = '0;
    {codeRd, codeAddr, dataWr, dataAddr, dataWdata} = '0;
  end
  // Register access; read data taken one cycle after the read edge
  task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    sfrWr <= wr;
    sfrRd <= !wr;
    sfrAddr <= a;
    sfrWdata <= d;
    @(posedge clk);
    sfrWr <= 1'b0;
    sfrRd <= 1'b0;
    sfrWdata <= ~d;
    #1 q = sfrRdata;
  endtask
  // Code fetch of n consecutive bytes
  task automatic cr(input logic [15:0] a, input int n);
    @(posedge clk);
    codeRd <= 1'b1;
    codeAddr <= a;
    repeat (n - 1) begin
      @(posedge clk);
      codeAddr <= codeAddr + 16'h0001;
    end
    @(posedge clk);
    codeRd <= 1'b0;
    codeAddr <= ~codeAddr;
  endtask
  // Data-move write
  task automatic dw(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    dataWr <= 1'b1;
    dataAddr <= a;
    dataWdata <= d;
    @(posedge clk);
    dataWr <= 1'b0;
    dataWdata <= ~d;
  endtask
  // Key pair ahead of each flash operation
  task automatic unlock();
    logic [7:0] q;
    sfr(1'b1, KEY_LOCK_OFS, KEY_FIRST, q);
    sfr(1'b1, KEY_LOCK_OFS, KEY_SECOND, q);
  endtask
  // Clock is above 10 MHz, so bypass the one-shot
  task automatic set_bypass();
    logic [7:0] q;
    sfr(1'b1, READ_SCALE_OFS, 8'hFF, q);
  endtask
  // Clear bypass, then a harmless three-byte fetch
  task automatic clear_bypass();
    logic [7:0] q;
    sfr(1'b1, READ_SCALE_OFS, 8'h00, q);
    cr(16'h0300, 3);
  endtask
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the program store access block
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); n_fail++; end end
module tb_top;
  import fps_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, flashOpData, ramWrData, q;
  logic sfrWr, sfrRd, codeRd, dataWr;
  logic [15:0] codeAddr, dataAddr, flashOpAddr, ramWrAddr;
  logic [7:0] dataWdata;
  logic flashSenseEn, flashLowPower, codeScratch, rowChange;
  logic flashProgStb, flashEraseStb, flashOpScratch, ramWrStb;
  fps_lock_t lockState;
  int n_fail = 0;
  int comparisons = 0;
  logic [15:0] rowAddr [4] = '{16'h0080, 16'h00FF, 16'h0100, 16'h017F};
  logic rowExp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // 20 MHz clock
  always #25 clk = ~clk;
  fps_program_store fps_program_store_i (.clk, .sys_rst(sysRst), .sfrAddr, .sfrWr,
    .sfrRd, .sfrWdata, .sfrRdata, .codeRd, .codeAddr, .dataWr, .dataAddr, .dataWdata,
    .flashSenseEn, .flashLowPower, .codeScratch, .rowChange, .flashProgStb,
    .flashEraseStb, .flashOpScratch, .flashOpAddr, .flashOpData, .ramWrStb, .ramWrAddr,
    .ramWrData, .lockState);
  fps_core_model core (.clk, .sfrAddr, .sfrWr, .sfrRd, .sfrWdata, .sfrRdata, .codeRd,
    .codeAddr, .dataWr, .dataAddr, .dataWdata);
  // Verdict and end of run
  task automatic report_and_stop();
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Mid-run reset
  task automatic do_reset();
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
  endtask
  // Strobes seen one cycle after a data-move write
  task automatic write_chk(input logic [15:0] a, input logic [7:0] d, input logic [2:0] e);
    core.dw(a, d);
    #1 `CHK({flashProgStb, flashEraseStb, ramWrStb}, e)
  endtask
  // Count sense-enable cycles around a fetch burst
  task automatic sense_count(input logic [15:0] a, input int n, input logic [7:0] e);
    logic [7:0] k;
    k = '0;
    fork
      core.cr(a, n);
      repeat (n + 3) begin
        @(posedge clk);
        #1 k = k + {7'h00, flashSenseEn};
      end
    join
    `CHK(k, e)
  endtask
  // Reset values and read-only bits
  task automatic t_regs();
    core.sfr(1'b0, PROG_STORE_CTRL_OFS, 8'h00, q);
    `CHK(q, 8'h00)
    core.sfr(1'b0, READ_SCALE_OFS, 8'h00, q);
    `CHK(q, 8'h00)
    core.sfr(1'b0, KEY_LOCK_OFS, 8'h00, q);
    `CHK(q, 8'h00)
    core.sfr(1'b1, PROG_STORE_CTRL_OFS, 8'hF8, q);
    core.sfr(1'b0, PROG_STORE_CTRL_OFS, 8'h00, q);
    `CHK(q, 8'h00)
    core.sfr(1'b1, 8'h90, 8'h5A, q);
    core.sfr(1'b0, 8'h90, 8'h00, q);
    `CHK(q, 8'h00)
  endtask
  // One-shot pulse, row changes, bypass and return
  task automatic t_sense();
    for (int i = 0; i < 4; i++) begin
      core.cr(rowAddr[i], 1);
      #1 `CHK({flashSenseEn, flashLowPower, rowChange}, {2'b10, rowExp[i]})
      @(posedge clk);
      #1 `CHK({flashSenseEn, flashLowPower}, 2'b01)
    end
    core.set_bypass();
    core.sfr(1'b0, READ_SCALE_OFS, 8'h00, q);
    `CHK(q, 8'h40)
    sense_count(16'h0180, 3, 8'h03);
    core.clear_bypass();
    core.sfr(1'b0, READ_SCALE_OFS, 8'h00, q);
    `CHK(q, 8'h00)
    sense_count(16'h0184, 1, 8'h01);
  endtask
  // Erase, program, relock and locked attempt
  task automatic t_flash();
    core.sfr(1'b1, PROG_STORE_CTRL_OFS, 8'h03, q);
    core.unlock();
    `CHK(lockState, LOCK_OPEN)
    write_chk(16'h0200, 8'h5A, 3'b010);
    `CHK({flashOpAddr, flashOpData, lockState}, {16'h0200, 8'hFF, LOCK_CLOSED})
    core.sfr(1'b1, PROG_STORE_CTRL_OFS, 8'h01, q);
    core.unlock();
    write_chk(16'h0201, 8'h3C, 3'b100);
    `CHK({flashOpAddr, flashOpData, flashOpScratch}, {16'h0201, 8'h3C, 1'b0})
    write_chk(16'h0202, 8'h11, 3'b000);
    `CHK(lockState, LOCK_DEAD)
    core.unlock();
    `CHK(lockState, LOCK_DEAD)
    do_reset();
    #1 `CHK(lockState, LOCK_CLOSED)
    core.sfr(1'b0, PROG_STORE_CTRL_OFS, 8'h00, q);
    `CHK(q, 8'h00)
  endtask
  // Scratchpad routing, plain data writes, wrong key
  task automatic t_route();
    core.sfr(1'b1, PROG_STORE_CTRL_OFS, 8'h05, q);
    core.unlock();
    write_chk(16'h0123, 8'h77, 3'b100);
    `CHK(flashOpScratch, 1'b1)
    core.cr(16'h0010, 1);
    #1 `CHK(codeScratch, 1'b1)
    core.sfr(1'b1, PROG_STORE_CTRL_OFS, 8'h00, q);
    core.cr(16'h0010, 1);
    #1 `CHK(codeScratch, 1'b0)
    write_chk(16'h4000, 8'h99, 3'b001);
    `CHK({ramWrAddr, ramWrData, lockState}, {16'h4000, 8'h99, LOCK_CLOSED})
    core.sfr(1'b1, KEY_LOCK_OFS, KEY_FIRST, q);
    `CHK(lockState, LOCK_FIRST)
    core.sfr(1'b1, KEY_LOCK_OFS, 8'h00, q);
    `CHK(lockState, LOCK_DEAD)
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    t_regs();
    t_sense();
    t_flash();
    t_route();
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule
